// ==== logic/comm_command_unit.v ====
// Communication command interpreter for a serial to single-wire bus master.
`timescale 1ns/1ps
`include "comm_cmd_regs.vh"

// What this block does
// - Bits 3..2 set speed; 11 means regular.
// - Single Bit slot type follows bit 4.
// - Single Bit answer echoes command, read in bits1..0.
// - Bit1 adds pullup, then EFh or ECh.
// - Accelerator control loads flag, no bus, no answer.
// - Accelerator on: data byte becomes twelve slots.
// - Accelerator control speed applies immediately.
// - Pulse bit4 picks pullup or program; bit1 arms.
// - F1h in command mode stops pulse at once.
// - Pulse answer at pulse end, low bits zero.
// - Armed data byte with accelerator off adds F6h or 76h byte.
// - Reset answer bits 7,6 ones, bit5 reserved.
// - One search answer byte per host byte.
// - Each search bit: two reads, then chosen write.
// - Answer pairs: flag even, chosen path odd.
// - Reset answer bits 4..2 carry revision code.
// - E1h enters data mode, E3h command mode.

module comm_command_unit #(
	parameter [2:0] REVISION = `REV_DEFAULT
) (
	input wire core_clk_in,
	input wire resetn_in,
	input wire rx_valid_in,
	input wire [7:0] rx_byte_in,
	input wire slot_done_in,
	input wire slot_read_in,
	input wire bus_reset_done_in,
	input wire [1:0] presence_code_in,
	input wire pulse_end_in,
	output reg tx_valid_out,
	output reg [7:0] tx_byte_out,
	output wire slot_req_out,
	output wire slot_value_out,
	output reg bus_reset_req_out,
	output reg [1:0] speed_code_out,
	output reg strong_pullup_out,
	output reg programming_supply_pin_out,
	output reg accel_on_out,
	output reg byte_pullup_armed_out,
	output reg [1:0] mode_out
);

	// ****************************************************************
	// State and working registers
	// ****************************************************************
	localparam S_IDLE = 3'h0;
	localparam S_SLOT = 3'h1;
	localparam S_DATA = 3'h2;
	localparam S_BIT_PULL = 3'h3;
	localparam S_DATA_PULL = 3'h4;
	localparam S_PULSE = 3'h5;
	localparam S_RESET = 3'h6;

	reg [2:0] state;
	reg [7:0] cmd;
	reg [7:0] data_byte;
	reg read_bit;
	reg eng_start;
	reg [1:0] eng_kind;
	reg [7:0] eng_data;
	reg err_clear;
	wire eng_done;
	wire [7:0] eng_result;

	// ****************************************************************
	// Slot sequencer
	// ****************************************************************
	slot_sequencer u_seq (
		.core_clk_in(core_clk_in),
		.resetn_in(resetn_in),
		.start_in(eng_start),
		.kind_in(eng_kind),
		.data_in(eng_data),
		.err_clear_in(err_clear),
		.slot_done_in(slot_done_in),
		.slot_read_in(slot_read_in),
		.slot_req_out(slot_req_out),
		.slot_value_out(slot_value_out),
		.done_out(eng_done),
		.result_out(eng_result)
	);

	// Maps the speed field; code 11 selects regular speed.
	function [1:0] speed_of;
		input [1:0] field;
		begin
			if (field == `SPEED_ALT_REGULAR)
				speed_of = `SPEED_REGULAR;
			else
				speed_of = field;
		end
	endfunction

	// Starts a data-mode byte as a plain byte or a search step.
	task start_data;
		input [7:0] b;
		begin
			data_byte <= b;
			eng_start <= 1'b1;
			eng_data <= b;
			eng_kind <= accel_on_out ? `KIND_SEARCH : `KIND_BYTE;
			state <= S_DATA;
		end
	endtask

	// Decodes and launches one command byte.
	task exec_cmd;
		input [7:0] c;
		begin
			cmd <= c;
			if (c == `OPC_DATA_MODE) begin
				mode_out <= `MODE_DATA;
			end else if (c == `OPC_CMD_MODE || c == `OPC_PULSE_STOP) begin
				mode_out <= `MODE_CMD;
			end else if (c[`F_CMD] && c[`F_MSB]) begin
				case (c[`F_FUNC_HI:`F_FUNC_LO])
				`FN_SINGLE: begin
					speed_code_out <= speed_of(c[`F_SPD_HI:`F_SPD_LO]);
					eng_start <= 1'b1;
					eng_kind <= `KIND_SINGLE;
					eng_data <= {7'h00, c[`F_SEL]};
					state <= S_SLOT;
				end
				`FN_ACCEL: begin
					speed_code_out <= speed_of(c[`F_SPD_HI:`F_SPD_LO]);
					accel_on_out <= c[`F_SEL];
					err_clear <= ~c[`F_SEL];
				end
				`FN_RESET: begin
					speed_code_out <= speed_of(c[`F_SPD_HI:`F_SPD_LO]);
					bus_reset_req_out <= 1'b1;
					state <= S_RESET;
				end
				default: begin
					if (c[`F_SPD_HI:`F_SPD_LO] == `PULSE_SPD) begin
						byte_pullup_armed_out <= c[`F_ARM];
						strong_pullup_out <= ~c[`F_SEL];
						programming_supply_pin_out <= c[`F_SEL];
						state <= S_PULSE;
					end
				end
				endcase
			end
		end
	endtask

	// ****************************************************************
	// Command interpreter
	// ****************************************************************
	// Byte dispatch, bus sequencing and response generation.
	always @(posedge core_clk_in) begin
		if (!resetn_in) begin
			state <= S_IDLE;
			mode_out <= `MODE_CMD;
			cmd <= 8'h00;
			data_byte <= 8'h00;
			read_bit <= 1'b0;
			eng_start <= 1'b0;
			eng_kind <= `KIND_SINGLE;
			eng_data <= 8'h00;
			err_clear <= 1'b0;
			tx_valid_out <= 1'b0;
			tx_byte_out <= 8'h00;
			bus_reset_req_out <= 1'b0;
			speed_code_out <= `SPEED_REGULAR;
			strong_pullup_out <= 1'b0;
			programming_supply_pin_out <= 1'b0;
			accel_on_out <= 1'b0;
			byte_pullup_armed_out <= 1'b0;
		end else begin
			tx_valid_out <= 1'b0;
			eng_start <= 1'b0;
			err_clear <= 1'b0;
			bus_reset_req_out <= 1'b0;
			case (state)
			S_IDLE: begin
				if (rx_valid_in) begin
					case (mode_out)
					`MODE_DATA: begin
						if (rx_byte_in == `OPC_CMD_MODE)
							mode_out <= `MODE_CHECK;
						else
							start_data(rx_byte_in);
					end
					`MODE_CHECK: begin
						// A doubled switch code goes to the bus once.
						if (rx_byte_in == `OPC_CMD_MODE) begin
							mode_out <= `MODE_DATA;
							start_data(rx_byte_in);
						end else begin
							mode_out <= `MODE_CMD;
							exec_cmd(rx_byte_in);
						end
					end
					default: exec_cmd(rx_byte_in);
					endcase
				end
			end
			S_SLOT: begin
				if (eng_done) begin
					read_bit <= eng_result[0];
					tx_valid_out <= 1'b1;
					tx_byte_out <= {cmd[7:2], eng_result[0], eng_result[0]};
					if (cmd[`F_ARM]) begin
						strong_pullup_out <= 1'b1;
						state <= S_BIT_PULL;
					end else begin
						state <= S_IDLE;
					end
				end
			end
			S_BIT_PULL: begin
				// The host stop code also ends this pullup early.
				if (pulse_end_in || (rx_valid_in &&
					rx_byte_in == `OPC_PULSE_STOP)) begin
					strong_pullup_out <= 1'b0;
					tx_valid_out <= 1'b1;
					tx_byte_out <= read_bit ? `RSP_BIT_PULL1 : `RSP_BIT_PULL0;
					state <= S_IDLE;
				end
			end
			S_DATA: begin
				if (eng_done) begin
					tx_valid_out <= 1'b1;
					tx_byte_out <= eng_result;
					// Per-byte pullup is skipped while the accelerator is on.
					if (byte_pullup_armed_out && !accel_on_out) begin
						strong_pullup_out <= 1'b1;
						state <= S_DATA_PULL;
					end else begin
						state <= S_IDLE;
					end
				end
			end
			S_DATA_PULL: begin
				if (pulse_end_in) begin
					strong_pullup_out <= 1'b0;
					tx_valid_out <= 1'b1;
					tx_byte_out <= data_byte[`F_MSB] ? `RSP_DATA_PULL1 :
						`RSP_DATA_PULL0;
					state <= S_IDLE;
				end
			end
			S_PULSE: begin
				// Timer, current demand or host stop code ends the pulse.
				if (pulse_end_in || (rx_valid_in &&
					rx_byte_in == `OPC_PULSE_STOP)) begin
					strong_pullup_out <= 1'b0;
					programming_supply_pin_out <= 1'b0;
					tx_valid_out <= 1'b1;
					tx_byte_out <= {cmd[7:2], `RSP_PULSE_LOW};
					state <= S_IDLE;
				end
			end
			S_RESET: begin
				if (bus_reset_done_in) begin
					tx_valid_out <= 1'b1;
					tx_byte_out <= {`RSP_RESET_TOP, `RSP_RESERVED, REVISION,
						presence_code_in};
					state <= S_IDLE;
				end
			end
			default: state <= S_IDLE;
			endcase
		end
	end

endmodule

// ==== logic/comm_cmd_regs.vh ====
// Constants shared by the communication command unit and its slot sequencer.
`ifndef COMM_CMD_REGS_VH
`define COMM_CMD_REGS_VH

// ********************************************************************
// Command byte fields
// ********************************************************************
`define F_FUNC_HI 7
`define F_FUNC_LO 5
`define F_SEL 4
`define F_SPD_HI 3
`define F_SPD_LO 2
`define F_ARM 1
`define F_CMD 0
`define F_MSB 7

// Function codes held in bits 7..5.
`define FN_SINGLE 3'h4
`define FN_ACCEL 3'h5
`define FN_RESET 3'h6
`define FN_PULSE 3'h7

// Speed field value that a Pulse command must carry.
`define PULSE_SPD 2'h3

// ********************************************************************
// Reserved codes and fixed response bytes
// ********************************************************************
`define OPC_DATA_MODE 8'he1
`define OPC_CMD_MODE 8'he3
`define OPC_PULSE_STOP 8'hf1
`define RSP_BIT_PULL1 8'hef
`define RSP_BIT_PULL0 8'hec
`define RSP_DATA_PULL1 8'hf6
`define RSP_DATA_PULL0 8'h76
`define RSP_RESET_TOP 2'h3
`define RSP_RESERVED 1'b0
`define RSP_PULSE_LOW 2'h0
`define REV_DEFAULT 3'h3

// ********************************************************************
// Speed codes, modes and sequencer kinds
// ********************************************************************
`define SPEED_REGULAR 2'h0
`define SPEED_FLEX 2'h1
`define SPEED_FAST 2'h2
`define SPEED_ALT_REGULAR 2'h3
`define MODE_CMD 2'h0
`define MODE_DATA 2'h1
`define MODE_CHECK 2'h2
`define KIND_SINGLE 2'h0
`define KIND_BYTE 2'h1
`define KIND_SEARCH 2'h2
`define LAST_SLOT 3'h7
`define LAST_SEARCH_BIT 2'h3

`endif

// ==== logic/slot_sequencer.v ====
// Slot sequencer: single slots, data bytes and accelerated search steps.
`timescale 1ns/1ps
`include "comm_cmd_regs.vh"

module slot_sequencer (
	input wire core_clk_in,
	input wire resetn_in,
	input wire start_in,
	input wire [1:0] kind_in,
	input wire [7:0] data_in,
	input wire err_clear_in,
	input wire slot_done_in,
	input wire slot_read_in,
	output reg slot_req_out,
	output reg slot_value_out,
	output reg done_out,
	output reg [7:0] result_out
);

	reg busy;
	reg [1:0] kind;
	reg [7:0] data;
	reg [2:0] cnt;
	reg [1:0] phase;
	reg first_read;
	reg search_err;
	wire [2:0] even_idx;
	wire [2:0] odd_idx;
	wire path_bit;
	wire no_answer;
	wire conflict;
	wire chosen;
	wire flag;

	// Search decision for the current identifier bit.
	assign even_idx = {cnt[1:0], 1'b0};
	assign odd_idx = {cnt[1:0], 1'b1};
	assign path_bit = data[odd_idx];
	assign no_answer = search_err | (first_read & slot_read_in);
	assign conflict = ~first_read & ~slot_read_in;
	assign chosen = no_answer ? 1'b1 : (conflict ? path_bit : first_read);
	assign flag = no_answer | conflict;

	// Issues one slot at a time and gathers the results.
	always @(posedge core_clk_in) begin
		if (!resetn_in) begin
			busy <= 1'b0;
			kind <= `KIND_SINGLE;
			data <= 8'h00;
			cnt <= 3'h0;
			phase <= 2'h0;
			first_read <= 1'b0;
			search_err <= 1'b0;
			slot_req_out <= 1'b0;
			slot_value_out <= 1'b1;
			done_out <= 1'b0;
			result_out <= 8'h00;
		end else begin
			slot_req_out <= 1'b0;
			done_out <= 1'b0;
			if (err_clear_in)
				search_err <= 1'b0;
			if (start_in && !busy) begin
				busy <= 1'b1;
				kind <= kind_in;
				data <= data_in;
				cnt <= 3'h0;
				phase <= 2'h0;
				slot_req_out <= 1'b1;
				// A read slot is the same as a write-one slot.
				slot_value_out <= (kind_in == `KIND_SEARCH) ? 1'b1 : data_in[0];
			end else if (busy && slot_done_in) begin
				case (kind)
				`KIND_SINGLE: begin
					result_out[0] <= slot_read_in;
					busy <= 1'b0;
					done_out <= 1'b1;
				end
				`KIND_BYTE: begin
					result_out[cnt] <= slot_read_in;
					if (cnt == `LAST_SLOT) begin
						busy <= 1'b0;
						done_out <= 1'b1;
					end else begin
						cnt <= cnt + 3'h1;
						slot_req_out <= 1'b1;
						slot_value_out <= data[cnt + 3'h1];
					end
				end
				default: begin
					// Two reads then one write for each of four bits.
					if (phase == 2'h0) begin
						first_read <= slot_read_in;
						phase <= 2'h1;
						slot_req_out <= 1'b1;
						slot_value_out <= 1'b1;
					end else if (phase == 2'h1) begin
						result_out[even_idx] <= flag;
						result_out[odd_idx] <= chosen;
						if (no_answer)
							search_err <= 1'b1;
						phase <= 2'h2;
						slot_req_out <= 1'b1;
						slot_value_out <= chosen;
					end else if (cnt[1:0] == `LAST_SEARCH_BIT) begin
						busy <= 1'b0;
						done_out <= 1'b1;
					end else begin
						cnt <= cnt + 3'h1;
						phase <= 2'h0;
						slot_req_out <= 1'b1;
						slot_value_out <= 1'b1;
					end
				end
				endcase
			end
		end
	end

endmodule

// ==== testbench/comm_cmd_properties.sv ====
// Port checker of the communication command unit.
`timescale 1ns/1ps
`include "comm_cmd_regs.vh"

module comm_cmd_checker #(
	parameter [2:0] REVISION = `REV_DEFAULT
) (
	input wire core_clk_in,
	input wire resetn_in,
	input wire rx_valid_in,
	input wire [7:0] rx_byte_in,
	input wire slot_done_in,
	input wire slot_read_in,
	input wire bus_reset_done_in,
	input wire [1:0] presence_code_in,
	input wire pulse_end_in,
	input wire tx_valid_out,
	input wire [7:0] tx_byte_out,
	input wire slot_req_out,
	input wire slot_value_out,
	input wire bus_reset_req_out,
	input wire [1:0] speed_code_out,
	input wire strong_pullup_out,
	input wire programming_supply_pin_out,
	input wire accel_on_out,
	input wire byte_pullup_armed_out,
	input wire [1:0] mode_out
);
	// A command byte taken in command mode while no pulse runs.
	wire pwr = strong_pullup_out | programming_supply_pin_out;
	wire cmd_take = rx_valid_in && mode_out == `MODE_CMD && !pwr &&
		rx_byte_in[`F_CMD] && rx_byte_in[`F_MSB];
	wire [2:0] fn = rx_byte_in[7:5];
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);

	// Each property ties an output to the input that caused it.
	property p_speed;
		cmd_take && fn != `FN_PULSE |=> speed_code_out ==
			(($past(rx_byte_in[3:2]) == 2'h3) ? 2'h0 : $past(rx_byte_in[3:2]));
	endproperty
	a_speed: assert property (p_speed) else $error("speed code wrong");
	property p_bus_reset;
		cmd_take && fn == `FN_RESET |=> bus_reset_req_out ##1 !bus_reset_req_out;
	endproperty
	a_bus_reset: assert property (p_bus_reset) else $error("no bus reset");
	property p_sb_slot;
		cmd_take && fn == `FN_SINGLE |=> ##1
			slot_req_out && slot_value_out == $past(rx_byte_in[4], 2);
	endproperty
	a_sb_slot: assert property (p_sb_slot) else $error("slot type wrong");
	property p_reset_ans;
		bus_reset_done_in |=> tx_valid_out && tx_byte_out[7:6] == 2'h3 &&
			tx_byte_out[4:2] == REVISION &&
			tx_byte_out[1:0] == $past(presence_code_in);
	endproperty
	a_reset_ans: assert property (p_reset_ans) else $error("reset answer");
	property p_accel;
		cmd_take && fn == `FN_ACCEL |=> accel_on_out == $past(rx_byte_in[4])
			&& !slot_req_out && !bus_reset_req_out ##1 !tx_valid_out;
	endproperty
	a_accel: assert property (p_accel) else $error("accel control");
	property p_pulse;
		cmd_take && fn == `FN_PULSE && rx_byte_in[3:2] == `PULSE_SPD |=>
			strong_pullup_out == !$past(rx_byte_in[4]) &&
			programming_supply_pin_out == $past(rx_byte_in[4]) &&
			byte_pullup_armed_out == $past(rx_byte_in[1]) && !tx_valid_out;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse start wrong");
	property p_stop;
		pwr && rx_valid_in && rx_byte_in == `OPC_PULSE_STOP &&
			mode_out == `MODE_CMD |=> !pwr && tx_valid_out;
	endproperty
	a_stop: assert property (p_stop) else $error("pulse not stopped");
	property p_pulse_end;
		pulse_end_in && pwr |=> !pwr && tx_valid_out;
	endproperty
	a_pulse_end: assert property (p_pulse_end) else $error("pulse end");
	property p_check_mode;
		rx_valid_in && mode_out == `MODE_DATA && rx_byte_in == `OPC_CMD_MODE
			|=> mode_out == `MODE_CHECK && !tx_valid_out && !slot_req_out;
	endproperty
	a_check_mode: assert property (p_check_mode) else $error("check mode");
	property p_slot_chain;
		slot_done_in && mode_out == `MODE_DATA |->
			(##1 slot_req_out) or (##2 tx_valid_out);
	endproperty
	a_slot_chain: assert property (p_slot_chain) else $error("stall");

	// Main scenarios reached.
	c_single: cover property (cmd_take && fn == `FN_SINGLE);
	c_pulse_end: cover property (pulse_end_in && pwr);
	c_search: cover property (accel_on_out && slot_done_in);
endmodule

bind comm_command_unit comm_cmd_checker #(.REVISION(REVISION)) chk_i (.*);

// ==== testbench/bus_side_model.sv ====
// Model of the bus timing engine and the slaves behind it.
`timescale 1ns/1ps

module bus_side_model (
	input wire core_clk_in,
	input wire slot_req_in,
	input wire slot_value_in,
	input wire bus_reset_req_in,
	input wire pullup_on_in,
	input wire bus_level_in,
	input wire [1:0] reaction_in,
	input wire auto_end_in,
	input wire [3:0] slow_in,
	output reg slot_done_out,
	output reg slot_read_out,
	output reg reset_done_out,
	output reg [1:0] presence_code_out,
	output reg pulse_end_out,
	output integer slot_count_out
);
	// Slots: a write-zero slot always reads low; idle read level flips.
	initial begin
		slot_done_out = 1'b0;
		slot_read_out = 1'b0;
		slot_count_out = 0;
		forever begin
			@(posedge core_clk_in);
			if (slot_req_in) begin
				repeat (slow_in) @(posedge core_clk_in);
				#1 slot_done_out = 1'b1;
				slot_read_out = slot_value_in & bus_level_in;
				slot_count_out = slot_count_out + 1;
				@(posedge core_clk_in);
				#1 slot_done_out = 1'b0;
				slot_read_out = ~slot_read_out;
			end
		end
	end

	// Bus reset answered with the chosen reaction.
	initial begin
		reset_done_out = 1'b0;
		presence_code_out = 2'h0;
		forever begin
			@(posedge core_clk_in);
			if (bus_reset_req_in) begin
				repeat (slow_in) @(posedge core_clk_in);
				#1 reset_done_out = 1'b1;
				presence_code_out = reaction_in;
				@(posedge core_clk_in);
				#1 reset_done_out = 1'b0;
				presence_code_out = ~reaction_in;
			end
		end
	end

	// Pullup or pulse ends by itself when the bench allows it.
	initial begin
		pulse_end_out = 1'b0;
		forever begin
			@(posedge core_clk_in);
			if (pullup_on_in && auto_end_in) begin
				repeat (slow_in + 2) @(posedge core_clk_in);
				#1 pulse_end_out = 1'b1;
				@(posedge core_clk_in);
				#1 pulse_end_out = 1'b0;
			end
		end
	end
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench of the communication command unit.
`timescale 1ns/1ps

module tb_top;
	localparam [2:0] REV = 3'h5;
	logic core_clk_in, resetn_in, rx_valid_in, slot_done_in, slot_read_in;
	logic bus_reset_done_in, pulse_end_in, tx_valid_out, slot_req_out;
	logic slot_value_out, bus_reset_req_out, strong_pullup_out;
	logic programming_supply_pin_out, accel_on_out, byte_pullup_armed_out;
	logic level, auto_end;
	logic [1:0] presence_code_in, speed_code_out, mode_out, reaction;
	logic [3:0] slow;
	logic [7:0] rx_byte_in, tx_byte_out, b;
	logic [7:0] sb_tab [4] = '{8'h91, 8'h85, 8'h99, 8'h8d};
	logic [7:0] pl_tab [3] = '{8'hed, 8'hfd, 8'hef};
	integer n_fail = 0, check_count = 0, cycles = 0, c0, slot_count;
	int i;

	comm_command_unit #(.REVISION(REV)) comm_command_unit_i (.*);
	bus_side_model bus_side_model_i (.core_clk_in(core_clk_in),
		.slot_req_in(slot_req_out), .slot_value_in(slot_value_out),
		.bus_reset_req_in(bus_reset_req_out),
		.pullup_on_in(strong_pullup_out | programming_supply_pin_out),
		.bus_level_in(level), .reaction_in(reaction),
		.auto_end_in(auto_end), .slow_in(slow),
		.slot_done_out(slot_done_in), .slot_read_out(slot_read_in),
		.reset_done_out(bus_reset_done_in),
		.presence_code_out(presence_code_in),
		.pulse_end_out(pulse_end_in), .slot_count_out(slot_count));

	// Verdict and end of run.
	task final_report;
		if (n_fail == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One host byte, held for one edge.
	task send(input logic [7:0] v);
		@(posedge core_clk_in);
		#1 rx_valid_in = 1'b1;
		rx_byte_in = v;
		@(posedge core_clk_in);
		#1 rx_valid_in = 1'b0;
		rx_byte_in = ~v;
	endtask
	// Waits a bounded time for one response byte.
	task expect_tx(input logic [7:0] exp);
		int k;
		k = 0;
		@(posedge core_clk_in);
		while (tx_valid_out !== 1'b1 && k < 300) begin
			@(posedge core_clk_in);
			k++;
		end
		chk("tx_byte", exp, (tx_valid_out === 1'b1) ? tx_byte_out : 8'hxx);
		#1;
	endtask
	task no_tx(input int n);
		repeat (n) begin
			@(posedge core_clk_in);
			chk("tx_valid", 8'h00, {7'h00, tx_valid_out});
		end
	endtask

	// Clock and hang guard.
	initial begin
		core_clk_in = 1'b0;
		forever #20 core_clk_in = ~core_clk_in;
	end
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			final_report();
		end
	end

	// Main sequence.
	initial begin
		resetn_in = 1'b0;
		rx_valid_in = 1'b0;
		rx_byte_in = 8'h00;
		level = 1'b1;
		reaction = 2'h0;
		auto_end = 1'b1;
		slow = 4'h3;
		repeat (8) @(posedge core_clk_in);
		#1 resetn_in = 1'b1;
		chk("mode", 8'h00, {6'h00, mode_out});
		chk("slot_value", 8'h01, {7'h00, slot_value_out});
		for (i = 0; i < 4; i++) begin
			b = sb_tab[i];
			send(b);
			chk("speed", {6'h00, (b[3:2] == 2'h3) ? 2'h0 : b[3:2]},
				{6'h00, speed_code_out});
			expect_tx({b[7:2], b[4], b[4]});
		end
		for (i = 0; i < 2; i++) begin
			level = i[0];
			send(8'h93);
			expect_tx({6'h24, level, level});
			chk("pullup", 8'h01, {7'h00, strong_pullup_out});
			expect_tx(level ? 8'hef : 8'hec);
		end
		// Stop code ends a held single-bit pullup; level is still high.
		auto_end = 1'b0;
		send(8'h93);
		expect_tx(8'h93);
		send(8'hf1);
		expect_tx(8'hef);
		chk("pullup", 8'h00, {7'h00, strong_pullup_out});
		auto_end = 1'b1;
		level = 1'b1;
		for (i = 0; i < 4; i++) begin
			reaction = i[1:0];
			send(8'hc1);
			expect_tx({2'h3, 1'b0, REV, reaction});
		end
		c0 = slot_count;
		send(8'hb5);
		chk("accel", 8'h01, {7'h00, accel_on_out});
		chk("speed", 8'h01, {6'h00, speed_code_out});
		no_tx(20);
		chk("slots", 8'h00, 8'(slot_count - c0));
		send(8'ha1);
		chk("accel", 8'h00, {7'h00, accel_on_out});
		// Configuration bytes and a pulse without speed 11 are ignored.
		send(8'h13);
		send(8'hf5);
		no_tx(10);
		chk("pullup", 8'h00, {7'h00, strong_pullup_out});
		for (i = 0; i < 3; i++) begin
			b = pl_tab[i];
			auto_end = (i != 0);
			send(b);
			chk("pullup", {7'h00, ~b[4]}, {7'h00, strong_pullup_out});
			chk("program", {7'h00, b[4]},
				{7'h00, programming_supply_pin_out});
			chk("armed", {7'h00, b[1]}, {7'h00, byte_pullup_armed_out});
			if (i == 0)
				send(8'hf1);
			expect_tx({b[7:2], 2'h0});
		end
		send(8'he1);
		chk("mode", 8'h01, {6'h00, mode_out});
		no_tx(5);
		for (i = 0; i < 2; i++) begin
			b = i ? 8'h5a : 8'ha5;
			c0 = slot_count;
			send(b);
			expect_tx(b);
			chk("slots", 8'h08, 8'(slot_count - c0));
			chk("pullup", 8'h01, {7'h00, strong_pullup_out});
			expect_tx(b[7] ? 8'hf6 : 8'h76);
		end
		send(8'he3);
		chk("mode", 8'h02, {6'h00, mode_out});
		send(8'he3);
		expect_tx(8'he3);
		expect_tx(8'hf6);
		chk("mode", 8'h01, {6'h00, mode_out});
		send(8'he3);
		send(8'hed);
		chk("mode", 8'h00, {6'h00, mode_out});
		expect_tx(8'hec);
		send(8'hb1);
		send(8'he1);
		level = 1'b0;
		slow = 4'h0;
		for (i = 0; i < 16; i++) begin
			b = {i[3], 1'b0, i[2], 1'b0, i[1], 1'b0, i[0], 1'b0};
			c0 = slot_count;
			send(b);
			expect_tx(b | 8'h55);
			chk("slots", 8'h0c, 8'(slot_count - c0));
		end
		send(8'he3);
		send(8'ha1);
		chk("accel", 8'h00, {7'h00, accel_on_out});
		final_report();
	end
endmodule
